// >>> src/flash_emulation_ram_map.sv
`timescale 1ns/1ps
`include "flash_emulation_ram_map_params.svh"


module flash_emulation_ram_map
  import flash_emulation_ram_map_pkg::*;
#(
  parameter bit FLASH_PRESENT = 1'b1,
  parameter int ADDR_W = 24
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire bus_addr_t reg_addr_i,
  input wire reg_byte_t reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output reg_byte_t reg_rdata_o,
  input wire op_mode_t mode_i,
  input wire bus_addr_t cpu_addr_i,
  output logic map_active_o,
  output logic ram_hit_o,
  output ram_offset_t ram_offset_o
);

  if (ADDR_W != 24) begin : g_bad_width
    $error("address width must be 24");
  end

  logic [`EMC_STORED_W-1:0] ctrl_q;
  logic [`EMC_STORED_W-1:0] ctrl_d;
  reg_byte_t rdata_q;
  reg_byte_t rdata_d;

  // only the low nibble is stored; the reserved bits are rebuilt on read
  localparam reg_byte_t CTRL_RESET_FULL = `EMC_RESET;

  wire logic addr_match;
  wire logic mode_writable;
  wire logic mode_single_normal;
  wire logic wr_take;
  wire logic rd_take;
  wire reg_byte_t reg_view;
  wire logic map_bit;
  wire block_sel_t block_sel;

  assign addr_match = (reg_addr_i == `EMC_ADDR);
  // modes 0 to 4 see the bits read-only
  assign mode_writable = (mode_i >= `MODE_WRITABLE_MIN);
  assign mode_single_normal = (mode_i == `MODE_SINGLE_NORMAL);

  // mode 6 still takes the write; only the mapping is held off
  assign wr_take = reg_we_i && addr_match && mode_writable
                   && FLASH_PRESENT;

  assign rd_take = reg_re_i && addr_match;

  assign reg_view = FLASH_PRESENT ? {`EMC_RSVD_FILL, ctrl_q}
                                  : `EMC_ABSENT_READ;

  assign rdata_d = rd_take ? reg_view : `EMC_UNMAPPED_READ;
  assign ctrl_d = wr_take ? reg_wdata_i[`EMC_STORED_W-1:0] : ctrl_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RESET_FULL[`EMC_STORED_W-1:0];
      rdata_q <= `EMC_UNMAPPED_READ;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  assign map_bit = ctrl_q[`EMC_ENABLE_BIT];
  assign block_sel = ctrl_q[`EMC_SEL_MSB:`EMC_SEL_LSB];

  // a stray one written in mode 6 (which software must avoid) stays inert
  assign map_active_o = FLASH_PRESENT && map_bit
                        && !mode_single_normal;

  ram_map_decoder u_decoder (
    .cpu_addr_i(cpu_addr_i),
    .map_active_i(map_active_o),
    .block_sel_i(block_sel),
    .ram_hit_o(ram_hit_o),
    .ram_offset_o(ram_offset_o)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge clk_sys_i);
  endclocking

  default disable iff (!resetn_i);

  wire logic in_fixed;
  wire logic in_low;
  wire logic in_sel_block;

  assign in_fixed = (cpu_addr_i[23:12] == `RAM_FIXED_PAGE);
  assign in_low = (cpu_addr_i <= `RAM_LOW_LIMIT);
  assign in_sel_block = (cpu_addr_i[23:12] == {`RAM_LOW_PAGE_TOP, block_sel});

  property p_fixed_window;
    !map_active_o && in_fixed |-> ram_hit_o
      && ram_offset_o == cpu_addr_i[11:0];
  endproperty
  a_fixed_window: assert property (p_fixed_window)
    else $error("fixed ram window not decoded");

  property p_map_write_to_hit;
    FLASH_PRESENT && reg_we_i && addr_match && mode_i == 3'h7
      && reg_wdata_i[3]
      ##1 (mode_i == 3'h7 && cpu_addr_i[23:12] == {9'h000,
        $past(reg_wdata_i[2:0])})
      |-> ram_hit_o;
  endproperty
  a_map_write_to_hit: assert property (p_map_write_to_hit)
    else $error("written block select did not map the ram");

  property p_low_redirect;
    map_active_o && in_sel_block |-> in_low && ram_hit_o
      && ram_offset_o == cpu_addr_i[11:0];
  endproperty
  a_low_redirect: assert property (p_low_redirect)
    else $error("selected low block not redirected to ram");

  property p_no_stray_hit;
    map_active_o && !in_sel_block |-> !ram_hit_o;
  endproperty
  a_no_stray_hit: assert property (p_no_stray_hit)
    else $error("ram hit outside the selected block");

  property p_mode6_inert;
    mode_single_normal |-> !map_active_o && (in_fixed == ram_hit_o);
  endproperty
  a_mode6_inert: assert property (p_mode6_inert)
    else $error("mapping active in single-chip normal mode");

  property p_mode6_writable;
    FLASH_PRESENT && reg_we_i && addr_match && mode_single_normal
      ##1 reg_re_i && addr_match
      |=> reg_rdata_o == {4'hf, $past(reg_wdata_i[3:0], 2)};
  endproperty
  a_mode6_writable: assert property (p_mode6_writable)
    else $error("write in single-chip normal mode not kept");

  property p_ro_modes;
    mode_i < 3'h5 |=> $stable(ctrl_q);
  endproperty
  a_ro_modes: assert property (p_ro_modes)
    else $error("control bits changed in a read-only mode");

  property p_absent_read;
    !FLASH_PRESENT && reg_re_i && addr_match |=> reg_rdata_o == 8'hff;
  endproperty
  a_absent_read: assert property (p_absent_read)
    else $error("variant without flash did not read all ones");

  property p_absent_write;
    !FLASH_PRESENT |-> ctrl_q == 4'h0 ##1 ctrl_q == 4'h0;
  endproperty
  a_absent_write: assert property (p_absent_write)
    else $error("variant without flash stored a write");

  property p_absent_no_map;
    !FLASH_PRESENT |-> !map_active_o && (ram_hit_o == in_fixed);
  endproperty
  a_absent_no_map: assert property (p_absent_no_map)
    else $error("mapping present on a variant without flash");

  property p_read_slot;
    reg_re_i && addr_match |=> reg_rdata_o[7:4] == 4'hf
      ##1 ($past(reg_re_i) || reg_rdata_o == 8'h00);
  endproperty
  a_read_slot: assert property (p_read_slot)
    else $error("read data outside its one-cycle slot");

  c_enable_map: cover property (
    reg_we_i && addr_match && mode_i == 3'h5 && reg_wdata_i[3]
    ##1 map_active_o);

  c_low_hit: cover property (map_active_o && ram_hit_o && in_low);

  c_mode6_write: cover property (
    reg_we_i && addr_match && mode_single_normal);

  c_back_to_back: cover property (
    reg_we_i && addr_match ##1 reg_re_i && addr_match);

endmodule // flash_emulation_ram_map

// >>> include/flash_emulation_ram_map_params.svh
`ifndef FLASH_EMULATION_RAM_MAP_PARAMS_SVH
`define FLASH_EMULATION_RAM_MAP_PARAMS_SVH

// register location on the byte-wide register port
`define EMC_ADDR 24'h0ee077

// emulation_map_control layout
`define EMC_RESET 8'hf0
`define EMC_RSVD_FILL 4'hf
`define EMC_ENABLE_BIT 3
`define EMC_SEL_MSB 2
`define EMC_SEL_LSB 0
`define EMC_STORED_W 4

// answer of a variant without flash, and of an idle or unmapped read
`define EMC_ABSENT_READ 8'hff
`define EMC_UNMAPPED_READ 8'h00

// ram windows
`define RAM_FIXED_PAGE 12'hffe
`define RAM_LOW_PAGE_TOP 9'h000
`define RAM_BLOCK_LOG2 12
`define RAM_LOW_LIMIT 24'h007fff

// operating modes
`define MODE_SINGLE_NORMAL 3'h6
`define MODE_WRITABLE_MIN 3'h5

`endif

// >>> include/flash_emulation_ram_map_pkg.sv
package flash_emulation_ram_map_pkg;
  typedef logic [23:0] bus_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] op_mode_t;
  typedef logic [2:0] block_sel_t;
  typedef logic [11:0] ram_offset_t;
endpackage

// >>> src/ram_map_decoder.sv
`timescale 1ns/1ps
`include "flash_emulation_ram_map_params.svh"

module ram_map_decoder
  import flash_emulation_ram_map_pkg::*;
(
  input wire bus_addr_t cpu_addr_i,
  input wire logic map_active_i,
  input wire block_sel_t block_sel_i,
  output logic ram_hit_o,
  output ram_offset_t ram_offset_o
);

  wire logic [11:0] page;
  wire logic fixed_hit;
  wire logic low_hit;

  assign page = cpu_addr_i[23:`RAM_BLOCK_LOG2];
  // the fixed window vanishes while the ram is mapped low
  assign fixed_hit = !map_active_i && (page == `RAM_FIXED_PAGE);
  assign low_hit = map_active_i && (page == {`RAM_LOW_PAGE_TOP, block_sel_i});
  assign ram_hit_o = fixed_hit || low_hit;
  assign ram_offset_o = cpu_addr_i[`RAM_BLOCK_LOG2-1:0];

endmodule // ram_map_decoder

// >>> tb/flash_emulation_ram_map_test.sv
`timescale 1ns/1ps
`include "flash_emulation_ram_map_params.svh"

module flash_emulation_ram_map_test;
  import flash_emulation_ram_map_pkg::*;
  logic clk_sys, resetn, we, re, act, rom_act, hit, rom_hit;
  bus_addr_t addr, cpu_addr;
  reg_byte_t wdata, rdata, rom_rdata;
  op_mode_t mode;
  ram_offset_t offs;
  int n_mismatch = 0;
  int checks_done = 0;

  flash_emulation_ram_map i_flash_emulation_ram_map (.clk_sys_i(clk_sys),
    .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .mode_i(mode),
    .cpu_addr_i(cpu_addr), .map_active_o(act), .ram_hit_o(hit),
    .ram_offset_o(offs));
  // mask-rom variant shares every input with the flash one
  flash_emulation_ram_map #(.FLASH_PRESENT(1'b0))
    i_flash_emulation_ram_map_rom (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rom_rdata), .mode_i(mode), .cpu_addr_i(cpu_addr),
    .map_active_o(rom_act), .ram_hit_o(rom_hit), .ram_offset_o());

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input bus_addr_t a, input reg_byte_t d);
    @(posedge clk_sys);
    we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    we <= 1'b0;
    #1;
  endtask

  // write, then read at the very next edge with no idle cycle between
  task automatic wr_rd(input bus_addr_t a, input reg_byte_t d,
                       input reg_byte_t exp);
    @(posedge clk_sys);
    we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    we <= 1'b0; re <= 1'b1;
    @(posedge clk_sys);
    re <= 1'b0;
    #1 chk("rdata_b2b", exp, rdata);
  endtask

  task automatic rd(input bus_addr_t a, input reg_byte_t exp);
    @(posedge clk_sys);
    re <= 1'b1; addr <= a;
    @(posedge clk_sys);
    re <= 1'b0;
    #1 chk("rdata", exp, rdata);
    if (a === `EMC_ADDR) chk("rom_rdata", 8'hff, rom_rdata);
    @(posedge clk_sys);
    #1 chk("rdata_idle", 8'h00, rdata);
  endtask

  task automatic probe(input bus_addr_t a, input logic h, input logic rh);
    @(posedge clk_sys);
    cpu_addr <= a;
    #1 chk("ram_hit", h, hit);
    chk("rom_ram_hit", rh, rom_hit);
    if (h) chk("ram_offset", a[11:0], offs);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    resetn = 1'b0; we = 1'b0; re = 1'b0; wdata = 8'h00;
    addr = `EMC_ADDR; mode = 3'h5; cpu_addr = 24'hffe123;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`EMC_ADDR, 8'hf0);
    probe(24'hffe123, 1'b1, 1'b1);
    for (int n = 0; n < 8; n++) begin
      wr(`EMC_ADDR, 8'h08 | 8'(n));
      chk("map_active", 1'b1, act);
      chk("rom_map_active", 1'b0, rom_act);
      probe(24'(n) * 24'h001000 + 24'h000abc, 1'b1, 1'b0);
      probe(24'((n + 1) % 8) * 24'h001000, 1'b0, 1'b0);
      probe(24'hffe123, 1'b0, 1'b1);
    end
    rd(`EMC_ADDR, 8'hff);
    wr(`EMC_ADDR, 8'h07);
    chk("map_active", 1'b0, act);
    probe(24'h007123, 1'b0, 1'b0);
    probe(24'hffe456, 1'b1, 1'b1);
    rd(`EMC_ADDR, 8'hf7);
    wr(24'h0ee076, 8'h0a);
    rd(`EMC_ADDR, 8'hf7);
    rd(24'h0ee076, 8'h00);
    wr(`EMC_ADDR, 8'h0c);
    chk("map_active", 1'b1, act);
    @(posedge clk_sys) mode <= 3'h6;
    #1 chk("map_active_mode6", 1'b0, act);
    probe(24'h004123, 1'b0, 1'b0);
    probe(24'hffe123, 1'b1, 1'b1);
    rd(`EMC_ADDR, 8'hfc);
    // software in this mode only ever clears the bits
    wr_rd(`EMC_ADDR, 8'h00, 8'hf0);
    wr(`EMC_ADDR, 8'h00);
    rd(`EMC_ADDR, 8'hf0);
    @(posedge clk_sys) mode <= 3'h4;
    wr(`EMC_ADDR, 8'h0d);
    rd(`EMC_ADDR, 8'hf0);
    @(posedge clk_sys) mode <= 3'h7;
    probe(24'h002fff, 1'b0, 1'b0);
    wr(`EMC_ADDR, 8'h0a);
    chk("map_active_mode7", 1'b1, act);
    chk("rom_map_active", 1'b0, rom_act);
    rd(`EMC_ADDR, 8'hfa);
    probe(24'h002fff, 1'b1, 1'b0);
    probe(24'h003000, 1'b0, 1'b0);
    tally_and_finish;
  end
endmodule // flash_emulation_ram_map_test
